// File: src/smc_delay_counter.sv
// loadable down counter timing start-up and resume holds
`timescale 1ns/1ps
`default_nettype none
module smc_delay_counter #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output var  logic         done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } smc_dly_st_t;
  smc_dly_st_t st_r;
  smc_dly_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
      st_nxt.cnt = loadVal;
    else if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // done ignores load: the loader decides on done, so a term on load would close a loop
  assign done = (st_r.cnt == '0);
endmodule : smc_delay_counter
`default_nettype wire

// File: src/smc_map.svh
// register offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
`define SMC_ADDR_PWR_CTRL      4'h0
`define SMC_ADDR_AUX_CFG       4'h1
`define SMC_ADDR_STATUS        4'h2
`define SMC_ADDR_STARTUP       4'h3
`define SMC_SE_BIT             7
`define SMC_SM_HI              6
`define SMC_SM_LO              4
`define SMC_PWR_CTRL_RST       8'h00
`define SMC_AUX_ASYNC_BIT      0
`define SMC_AUX_CMPDIS_BIT     1
`define SMC_AUX_XTAL_BIT       2
`define SMC_AUX_CFG_RST        8'h00
`define SMC_STARTUP_RST        8'h06
`define SMC_RESUME_CYCLES      4'h4
`define SMC_STANDBY_CYCLES     8'h06
`endif

// File: src/smc_mode_decode.sv
// combinational decode of sleep mode into clock gates and wake filter
`timescale 1ns/1ps
`default_nettype none
module smc_mode_decode (
  input  wire logic [2:0]        modeCode,
  input  wire logic              xtalSel,
  output var  logic              modeValid,
  output var  smc_pkg::smc_clk_t clkOn,
  output var  smc_pkg::smc_wake_t wakeEn
);
  always_comb
  begin
    modeValid = 1'b1;
    clkOn     = '0;
    wakeEn    = '0;
    unique case (smc_pkg::smc_mode_t'(modeCode)) // [RULE_02]
      smc_pkg::SMC_IDLE:
      begin
        clkOn  = '{coreClk: 1'b0, flashClk: 1'b0, ioClk: 1'b1, convClk: 1'b1, asyncClk: 1'b1, mainOsc: 1'b1}; // [RULE_06]
        wakeEn = '1; // [RULE_07]
      end
      smc_pkg::SMC_ADCNR:
      begin
        clkOn  = '{coreClk: 1'b0, flashClk: 1'b0, ioClk: 1'b0, convClk: 1'b1, asyncClk: 1'b1, mainOsc: 1'b1}; // [RULE_09]
        wakeEn = '{extLevel: 1'b1, twiMatch: 1'b1, auxTimer: 1'b1, nvReady: 1'b1, convDone: 1'b1,
                   otherIo: 1'b0, cmpIrq: 1'b0}; // [RULE_10]
      end
      smc_pkg::SMC_PDOWN:
      begin
        wakeEn.extLevel = 1'b1; // [RULE_11]
        wakeEn.twiMatch = 1'b1; // [RULE_11]
      end
      smc_pkg::SMC_PSAVE:
      begin
        clkOn.asyncClk  = 1'b1; // [RULE_15]
        wakeEn.extLevel = 1'b1; // [RULE_14]
        wakeEn.twiMatch = 1'b1;
        wakeEn.auxTimer = 1'b1;
      end
      smc_pkg::SMC_STANDBY:
      begin
        modeValid       = xtalSel; // [RULE_17]
        clkOn.mainOsc   = 1'b1; // [RULE_17]
        wakeEn.extLevel = 1'b1;
        wakeEn.twiMatch = 1'b1;
      end
      default:
        modeValid = 1'b0; // [RULE_20]
    endcase
  end
endmodule : smc_mode_decode
`default_nettype wire

// File: src/smc_pkg.sv
// types of the sleep controller
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_IDLE    = 3'h0,
    SMC_ADCNR   = 3'h1,
    SMC_PDOWN   = 3'h2,
    SMC_PSAVE   = 3'h3,
    SMC_RSV4    = 3'h4,
    SMC_RSV5    = 3'h5,
    SMC_STANDBY = 3'h6,
    SMC_RSV7    = 3'h7
  } smc_mode_t;

  typedef struct packed {
    logic coreClk;
    logic flashClk;
    logic ioClk;
    logic convClk;
    logic asyncClk;
    logic mainOsc;
  } smc_clk_t;

  typedef struct packed {
    logic extLevel;
    logic twiMatch;
    logic auxTimer;
    logic nvReady;
    logic convDone;
    logic otherIo;
    logic cmpIrq;
  } smc_wake_t;

  typedef enum logic [3:0] {
    SMC_RUN    = 4'b0001,
    SMC_SLEEP  = 4'b0010,
    SMC_START  = 4'b0100,
    SMC_RESUME = 4'b1000
  } smc_state_t;
endpackage : smc_pkg

// File: src/smc_sleep_ctrl.sv
// sleep mode controller: mode register, clock gating, wake filtering and resume sequencing
//
// Function
// [RULE_01] sleep only if sleep enable is one when halt executes
// [RULE_02] mode 000 idle, 001 noise, 010 down, 011 save, 110 standby, others reserved
// [RULE_03] interrupt wake holds core four cycles past start-up then resumes after halt
// [RULE_04] register file and sram contents unchanged by sleeping
// [RULE_05] reset during sleep wakes and restarts at reset vector
// [RULE_06] idle stops only core and flash clocks
// [RULE_07] idle wakes on any enabled interrupt
// [RULE_08] idle or noise mode starts a conversion when converter enabled
// [RULE_09] noise mode stops io, core and flash clocks
// [RULE_10] noise mode wakes only on its listed sources
// [RULE_11] power-down stops oscillator, wakes on reset, two-wire match, level interrupt
// [RULE_12] power-down wake waits the fuse-chosen start-up delay
// [RULE_13] level interrupt must be held long enough to wake from power-down
// [RULE_14] power-save adds async aux timer wake when its enables are set
// [RULE_15] power-save halts every clock except the async clock
// [RULE_16] software should prefer power-down when aux timer is synchronous
// [RULE_17] standby needs code 110 and crystal, keeps oscillator, wakes in 6 cycles
// [RULE_18] software should set sleep enable just before halt
// [RULE_19] comparator disable removes comparator wake in idle
// [RULE_20] sleep enable zero or reserved code makes halt a no-op
// [RULE_21] gating applied at halt retirement, released after wake delay
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
module smc_sleep_ctrl (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // register port
  input  wire logic [3:0]         regAddr,
  input  wire logic [7:0]         regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output var  logic [7:0]         regRdata,
  // core side
  input  wire logic               haltExec,
  input  wire logic               globalIrqEn,
  input  wire logic               convEnabled,
  output var  logic               coreHalt,
  output var  logic               haltNop,
  output var  logic               resumeIrq,
  output var  logic               resumeReset,
  output var  logic               convStart,
  // clock enables
  output var  smc_pkg::smc_clk_t  clkEnable,
  // wake sources, already enabled at their source
  input  wire smc_pkg::smc_wake_t wakeReq,
  input  wire logic               auxTimerIrqEn,
  input  wire logic               wakeReset
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]          pwrCtrl;
    logic [7:0]          auxCfg;
    logic [7:0]          startup;
    smc_pkg::smc_state_t state;
    logic [2:0]          mode;
    logic                byReset;
    logic [7:0]          rdata;
    logic                coreHalt;
    logic                haltNop;
    logic                resumeIrq;
    logic                resumeReset;
    logic                convStart;
    smc_pkg::smc_clk_t   clk;
    logic [1:0]          wakeSync0;
    logic [1:0]          wakeSync1;
  } smc_st_t;

  smc_st_t            st_r;
  smc_st_t            st_nxt;
  logic               modeValid;
  smc_pkg::smc_clk_t  modeClk;
  smc_pkg::smc_wake_t modeWake;
  smc_pkg::smc_wake_t wakeMask;
  logic               wakeHit;
  logic               dlyLoad;
  logic [7:0]         dlyVal;
  logic               dlyDone;
  logic [2:0]         curMode;
  logic               sleepGo;

  localparam smc_pkg::smc_clk_t CLK_ALL = '1;

  //////////////////////////////////////////////////////////////////////////////
  // idle and noise keep the converter clock and the main oscillator, so they need no start-up wait
  function automatic logic smc_conv_mode(input logic [2:0] code);
    return (code == smc_pkg::SMC_IDLE) || (code == smc_pkg::SMC_ADCNR);
  endfunction : smc_conv_mode

  // start-up hold chosen by the mode that was asleep
  function automatic logic [7:0] smc_wake_delay(input logic [2:0] code, input logic [7:0] startup);
    logic [7:0] dly;
    dly = startup; // [RULE_12]
    if (code == smc_pkg::SMC_STANDBY)
      dly = `SMC_STANDBY_CYCLES; // [RULE_17]
    else if (smc_conv_mode(code))
      dly = 8'h00;
    return dly;
  endfunction : smc_wake_delay

  //////////////////////////////////////////////////////////////////////////////
  // decode the mode captured at halt while asleep, else the live field
  assign curMode = (st_r.state == smc_pkg::SMC_RUN)
                   ? st_r.pwrCtrl[`SMC_SM_HI:`SMC_SM_LO] : st_r.mode;

  smc_mode_decode u_decode (
    .modeCode  (curMode),
    .xtalSel   (st_r.auxCfg[`SMC_AUX_XTAL_BIT]),
    .modeValid (modeValid),
    .clkOn     (modeClk),
    .wakeEn    (modeWake)
  );

  always_comb
  begin
    wakeMask = modeWake;
    if (st_r.auxCfg[`SMC_AUX_CMPDIS_BIT])
      wakeMask.cmpIrq = 1'b0; // [RULE_19]
    if (st_r.mode == smc_pkg::SMC_PSAVE)
      wakeMask.auxTimer = st_r.auxCfg[`SMC_AUX_ASYNC_BIT] && auxTimerIrqEn && globalIrqEn; // [RULE_14]
  end

  // level wake inputs come from other domains and are synchronised first;
  // a short level pulse can be missed while asleep, so the source must hold it
  assign wakeHit = |({st_r.wakeSync1, wakeReq[4:0]} & wakeMask); // [RULE_13]
  assign sleepGo = haltExec && st_r.pwrCtrl[`SMC_SE_BIT] && modeValid; // [RULE_01] [RULE_20]

  always_comb
  begin
    dlyLoad = 1'b0;
    dlyVal  = st_r.startup;
    if (st_r.state == smc_pkg::SMC_SLEEP && (wakeHit || wakeReset))
    begin
      dlyLoad = 1'b1;
      dlyVal  = smc_wake_delay(st_r.mode, st_r.startup); // [RULE_12] [RULE_17]
    end
    else if (st_r.state == smc_pkg::SMC_START && dlyDone)
    begin
      dlyLoad = 1'b1;
      dlyVal  = {4'h0, `SMC_RESUME_CYCLES}; // [RULE_03]
    end
  end

  smc_delay_counter #(.W(8)) u_delay (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (dlyLoad),
    .loadVal (dlyVal),
    .done    (dlyDone)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt             = st_r;
    st_nxt.wakeSync0   = {wakeReq.extLevel, wakeReq.twiMatch};
    st_nxt.wakeSync1   = st_r.wakeSync0;
    st_nxt.haltNop     = 1'b0;
    st_nxt.resumeIrq   = 1'b0;
    st_nxt.resumeReset = 1'b0;
    st_nxt.convStart   = 1'b0;
    st_nxt.rdata       = 8'h00;

    if (regWr)
    begin
      unique case (regAddr)
        `SMC_ADDR_PWR_CTRL: st_nxt.pwrCtrl = {regWdata[7:4], 4'h0};
        `SMC_ADDR_AUX_CFG:  st_nxt.auxCfg  = {5'h00, regWdata[2:0]};
        `SMC_ADDR_STARTUP:  st_nxt.startup = regWdata;
        default:            st_nxt.rdata   = 8'h00;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        `SMC_ADDR_PWR_CTRL: st_nxt.rdata = st_r.pwrCtrl;
        `SMC_ADDR_AUX_CFG:  st_nxt.rdata = st_r.auxCfg;
        `SMC_ADDR_STATUS:   st_nxt.rdata = {st_r.byReset, st_r.mode, st_r.state};
        `SMC_ADDR_STARTUP:  st_nxt.rdata = st_r.startup;
        default:            st_nxt.rdata = 8'h00;
      endcase
    end

    unique case (st_r.state)
      smc_pkg::SMC_RUN:
      begin
        if (sleepGo)
        begin
          st_nxt.state    = smc_pkg::SMC_SLEEP; // [RULE_21]
          st_nxt.mode     = curMode;
          st_nxt.coreHalt = 1'b1;
          st_nxt.clk      = modeClk; // [RULE_06] [RULE_09] [RULE_11] [RULE_15]
          st_nxt.convStart = convEnabled && smc_conv_mode(curMode); // [RULE_08]
        end
        else if (haltExec)
          st_nxt.haltNop = 1'b1; // [RULE_20]
      end
      smc_pkg::SMC_SLEEP:
      begin
        // only clocks are gated; storage is never cleared here
        if (wakeReset)
          st_nxt.byReset = 1'b1; // [RULE_05]
        if (wakeReset || wakeHit)
        begin
          st_nxt.state   = smc_pkg::SMC_START;
          st_nxt.clk.mainOsc = 1'b1;
        end
      end
      smc_pkg::SMC_START:
      begin
        if (dlyDone)
        begin
          st_nxt.clk   = CLK_ALL; // [RULE_04]
          st_nxt.state = smc_pkg::SMC_RESUME;
        end
      end
      smc_pkg::SMC_RESUME:
      begin
        if (dlyDone)
        begin
          st_nxt.state       = smc_pkg::SMC_RUN; // [RULE_21]
          st_nxt.coreHalt    = 1'b0;
          st_nxt.resumeReset = st_r.byReset; // [RULE_05]
          st_nxt.resumeIrq   = !st_r.byReset; // [RULE_03]
          st_nxt.byReset     = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r         <= '0;
      st_r.state   <= smc_pkg::SMC_RUN;
      st_r.pwrCtrl <= `SMC_PWR_CTRL_RST;
      st_r.auxCfg  <= `SMC_AUX_CFG_RST;
      st_r.startup <= `SMC_STARTUP_RST;
      st_r.clk     <= '1;
    end
    else
      st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign regRdata    = st_r.rdata;
  assign coreHalt    = st_r.coreHalt;
  assign haltNop     = st_r.haltNop;
  assign resumeIrq   = st_r.resumeIrq;
  assign resumeReset = st_r.resumeReset;
  assign convStart   = st_r.convStart;
  assign clkEnable   = st_r.clk;
endmodule : smc_sleep_ctrl
`default_nettype wire

// File: verif/smc_core_model.sv
// core and wake-source model facing the sleep controller
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               sleepGo,
  input  wire logic               wakeGo,
  input  wire smc_pkg::smc_wake_t wakeSel,
  input  wire logic               coreHalt,
  output var  logic               haltExec,
  output var  smc_pkg::smc_wake_t wakeReq
);
  logic holdR;
  logic haltR;
  always_ff @(posedge ref_clk)
  begin
    haltExec <= sleepGo & ~rst; // halt follows sleepGo one clock later
    haltR <= coreHalt;
    if (rst || (haltR && !coreHalt))
      holdR <= 1'b0;
    else if (wakeGo)
      holdR <= 1'b1;
  end
  // level stays until the core is back, the synchroniser needs it
  assign wakeReq = holdR ? wakeSel : '0;
endmodule : smc_core_model
`default_nettype wire

// File: verif/smc_sleep_asserts.sv
// port assertions of the sleep controller
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_asserts (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [3:0]        regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  input wire logic              haltExec,
  input wire logic              convEnabled,
  input wire logic              coreHalt,
  input wire logic              haltNop,
  input wire logic              resumeIrq,
  input wire logic              resumeReset,
  input wire logic              convStart,
  input wire smc_pkg::smc_clk_t clkEnable
);
  logic       enR;
  logic       xtR;
  logic [2:0] mdR;
  logic       ok;
  ////////////////////////////////////////
  // shadow of the mode bits, written only through the port
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      enR <= 1'b0;
      mdR <= 3'h0;
      xtR <= 1'b0;
    end
    else if (regWr && regAddr == 4'h0)
    begin
      enR <= regWdata[7];
      mdR <= regWdata[6:4];
    end
    else if (regWr && regAddr == 4'h1)
      xtR <= regWdata[2];
  end
  assign ok = enR && (mdR < 3'h4 || (mdR == 3'h6 && xtR));
  ////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_nop; haltExec && !ok |=> haltNop && !coreHalt; endproperty
  a_nop: assert property (p_nop) else $error("halt not ignored");
  property p_idle; haltExec && ok && mdR == 3'h0 |=> coreHalt && clkEnable == 6'h0F; endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  property p_noise; haltExec && ok && mdR == 3'h1 |=> clkEnable == 6'h07; endproperty
  a_noise: assert property (p_noise) else $error("noise gating wrong");
  property p_pdown; haltExec && ok && mdR == 3'h2 |=> clkEnable == 6'h00; endproperty
  a_pdown: assert property (p_pdown) else $error("power-down gating wrong");
  property p_psave; haltExec && ok && mdR == 3'h3 |=> clkEnable[5:2] == 4'h0 && !clkEnable.mainOsc; endproperty
  a_psave: assert property (p_psave) else $error("power-save gating wrong");
  property p_stby; haltExec && ok && mdR == 3'h6 |=> clkEnable == 6'h01; endproperty
  a_stby: assert property (p_stby) else $error("standby gating wrong");
  property p_conv; haltExec && ok && convEnabled && mdR[2:1] == 2'h0 |=> convStart; endproperty
  a_conv: assert property (p_conv) else $error("no conversion start");
  property p_resume; $fell(coreHalt) |-> (resumeIrq ^ resumeReset) && clkEnable == 6'h3F; endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  property p_rd; regRd && regAddr == 4'h0 |=> regRdata == {enR, mdR, 4'h0}; endproperty
  a_rd: assert property (p_rd) else $error("control read wrong");
  c_idle: cover property (haltExec && ok && mdR == 3'h0);
  c_nop: cover property (haltNop);
  c_rst: cover property (resumeReset);
endmodule : smc_sleep_asserts
bind smc_sleep_ctrl smc_sleep_asserts chk_u (.*);
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the sleep controller
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
module tb;
  logic ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdP = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, st, d;
  logic haltExec, coreHalt, haltNop, resumeIrq, resumeReset, convStart, en, xt, ok;
  logic globalIrqEn = 1'b1, auxTimerIrqEn = 1'b1, convEnabled = 1'b0, wakeReset = 1'b0;
  logic sleepGo = 1'b0, wakeGo = 1'b0;
  logic [2:0] md;
  smc_pkg::smc_clk_t clkEnable;
  smc_pkg::smc_wake_t wakeReq, wakeSel = '0;
  logic [6:0] wk [8] = '{7'h02, 7'h04, 7'h40, 7'h10, 7'h00, 7'h00, 7'h20, 7'h00};
  logic [6:0] nw [8] = '{7'h01, 7'h02, 7'h08, 7'h14, 7'h00, 7'h00, 7'h10, 7'h00};
  logic [7:0] rdQ [$], evQ [$];
  int mismatches = 0, n_checks = 0, cyc = 0, lat, seed = 32'hc4c0e755;
  always #10 ref_clk = ~ref_clk;
  smc_sleep_ctrl dut_u (.*);
  smc_core_model core_u (.*);
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(v);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd
  task automatic halt(input logic [7:0] ev);
    evQ.push_back(ev);
    sleepGo <= 1'b1;
    @(posedge ref_clk);
    sleepGo <= 1'b0;
  endtask : halt
  ////////////////////////////////////////
  // results are matched in order against what the driver expected
  always @(posedge ref_clk)
  begin
    if (rdP)
      check("regRdata", regRdata, rdQ.size() ? rdQ.pop_front() : 8'hEE);
    if (resumeIrq | resumeReset | haltNop)
      check("event", {5'h0, resumeIrq, resumeReset, haltNop}, evQ.size() ? evQ.pop_front() : 8'hEE);
    rdP <= regRd;
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SMC_ADDR_PWR_CTRL, `SMC_PWR_CTRL_RST);
    rd(`SMC_ADDR_AUX_CFG, `SMC_AUX_CFG_RST);
    rd(`SMC_ADDR_STARTUP, `SMC_STARTUP_RST);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 10; i++)
    begin
      en = (i != 9);
      xt = (i != 8);
      md = (i < 8) ? i[2:0] : ((i == 8) ? 3'h6 : 3'h0);
      ok = en && xt && (md < 3'h4 || md == 3'h6);
      st = 8'h08 + 8'($random(seed) & 7);
      d = (md == 3'h6) ? 8'h06 : (md[1] ? st : 8'h00);
      wr(`SMC_ADDR_STARTUP, st);
      wr(`SMC_ADDR_AUX_CFG, {5'h0, xt, 2'h3}); // aux timer async whenever power-save runs
      convEnabled <= i[0];
      wr(`SMC_ADDR_PWR_CTRL, {en, md, 4'($random(seed))});
      rd(`SMC_ADDR_PWR_CTRL, {en, md, 4'h0});
      halt(ok ? 8'h04 : 8'h01);
      repeat (3) @(negedge ref_clk);
      check("halted", coreHalt, ok);
      if (ok)
      begin
        @(posedge ref_clk);
        wakeSel <= nw[md];
        globalIrqEn <= (md != 3'h3); // aux timer stays masked without global enable
        wakeGo <= 1'b1;
        @(posedge ref_clk);
        wakeGo <= 1'b0;
        repeat (20) @(negedge ref_clk);
        check("no wake", coreHalt, 1'b1);
        rd(`SMC_ADDR_STATUS, {1'b0, md, 4'h2});
        @(posedge ref_clk);
        wakeSel <= wk[md];
        globalIrqEn <= 1'b1;
        lat = 0;
        @(negedge ref_clk);
        while (coreHalt === 1'b1 && lat < 300)
        begin
          @(negedge ref_clk);
          lat++;
        end
        check("wake delay", lat >= d + 4 && lat <= d + 12, 1'b1);
        @(posedge ref_clk);
        wakeSel <= '0;
      end
      $display("test mode %0d done", i);
    end
    wr(`SMC_ADDR_PWR_CTRL, 8'hA0);
    halt(8'h02);
    repeat (5) @(posedge ref_clk);
    wakeReset <= 1'b1;
    @(posedge ref_clk);
    wakeReset <= 1'b0;
    repeat (40) @(negedge ref_clk);
    check("reset wake", coreHalt, 1'b0);
    check("events left", 8'(evQ.size()), 8'h00);
    $display("test reset wake done");
    results();
  end
endmodule : tb
`default_nettype wire
